/* src/rem_consts.svh */
// Behaviour
// - Count per-link packets with header length mismatch
// - Four link instances, selector picks read instance
// - Per-link sticky stream packet length fault bit
// - Count corrected header and trailer errors per link
// - Corrected tally thirteen bits, count in 11:0
// - Bit 12 sets on count overflow
// - Sticky flag for corrected trigger packet errors
// - Sticky flag for corrected trigger reply errors
// - Sticky flag for corrected stream data errors
// - Sticky flag for corrected acknowledge packet errors
// - Sticky flag for corrected link test errors
// - Sticky flag for corrected heartbeat packet errors
`ifndef REM_CONSTS_SVH
`define REM_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define REM_OFF_SEL 12'h000
`define REM_OFF_LEN_TALLY 12'h004
`define REM_OFF_FLAGS 12'h008
`define REM_OFF_FIX_TALLY 12'h00C
`define REM_OFF_IRQ_STAT 12'h010
`define REM_OFF_IRQ_MASK 12'h014

// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define REM_LINKS 4
`define REM_CNT_W 12
`define REM_OVF_BIT 12
`define REM_FLG_STREAM_LEN 0
`define REM_FLG_TRIG 1
`define REM_FLG_TRIG_REPLY 2
`define REM_FLG_STREAM_DATA 3
`define REM_FLG_CTRL_REPLY 4
`define REM_FLG_LINK_PROBE 5
`define REM_FLG_KEEPALIVE 6
`define REM_NUM_FLAGS 7

// ----------------------------------------
// Interrupt status bits (per link, one byte each)
// ----------------------------------------
`define REM_IRQ_LEN 0
`define REM_IRQ_FIX 1
`define REM_IRQ_OVF 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define REM_RST_CNT 13'h0000
`define REM_RST_FLAGS 7'h00
`define REM_RST_WORD 32'h0000_0000

`endif

/* src/rem_pkg.sv */
package rem_pkg;
   // Packet types reported with a corrected error
   typedef enum logic [2:0] {
      REM_PT_TRIG = 3'h0,
      REM_PT_TRIG_REPLY = 3'h1,
      REM_PT_STREAM = 3'h2,
      REM_PT_CTRL_REPLY = 3'h3,
      REM_PT_LINK_PROBE = 3'h4,
      REM_PT_KEEPALIVE = 3'h5
   } rem_ptype_t;

   // Bus slave phases
   typedef enum logic [2:0] {
      REM_BUS_IDLE = 3'b001,
      REM_BUS_ACCESS = 3'b010,
      REM_BUS_DONE = 3'b100
   } rem_bus_st_t;

   // One wrapping error tally with a sticky overflow bit
   typedef struct packed {
      logic ovf;
      logic [11:0] cnt;
   } rem_tally_t;
endpackage : rem_pkg

/* src/rem_link_mon.sv */
`include "rem_consts.svh"

// Monitor state for one link
module rem_link_mon
   import rem_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_len_err,
   input wire logic i_len_stream,
   input wire logic i_fix_err,
   input wire logic [2:0] i_fix_type,
   output logic [12:0] o_len_tally,
   output logic [12:0] o_fix_tally,
   output logic [6:0] o_flags
);
   typedef struct packed {
      rem_tally_t len;
      rem_tally_t fix;
      logic [6:0] flags;
   } rem_link_st_t;

   rem_link_st_t st_reg;
   rem_link_st_t st_next;

   // Advance a tally; overflow bit is sticky once the count wraps
   function automatic rem_tally_t rem_bump(input rem_tally_t t);
      rem_tally_t r;
      r = t;
      if (t.cnt == 12'hFFF) begin
         r.ovf = 1'b1;
      end
      r.cnt = t.cnt + 12'h001;
      return r;
   endfunction : rem_bump

   // Next state of tallies and sticky flags
   always_comb begin
      st_next = st_reg;
      if (i_len_err) begin
         st_next.len = rem_bump(st_reg.len);
         if (i_len_stream) begin
            st_next.flags[`REM_FLG_STREAM_LEN] = 1'b1;
         end
      end
      if (i_fix_err) begin
         st_next.fix = rem_bump(st_reg.fix);
         case (rem_ptype_t'(i_fix_type))
            REM_PT_TRIG: st_next.flags[`REM_FLG_TRIG] = 1'b1;
            REM_PT_TRIG_REPLY: st_next.flags[`REM_FLG_TRIG_REPLY] = 1'b1;
            REM_PT_STREAM: st_next.flags[`REM_FLG_STREAM_DATA] = 1'b1;
            REM_PT_CTRL_REPLY: st_next.flags[`REM_FLG_CTRL_REPLY] = 1'b1;
            REM_PT_LINK_PROBE: st_next.flags[`REM_FLG_LINK_PROBE] = 1'b1;
            REM_PT_KEEPALIVE: st_next.flags[`REM_FLG_KEEPALIVE] = 1'b1;
            default: st_next.flags = st_next.flags;
         endcase
      end
   end

   // State register, cleared only by reset
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_reg.len <= `REM_RST_CNT;
         st_reg.fix <= `REM_RST_CNT;
         st_reg.flags <= `REM_RST_FLAGS;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_len_tally = st_reg.len;
   assign o_fix_tally = st_reg.fix;
   assign o_flags = st_reg.flags;
endmodule : rem_link_mon

/* src/rem_rx_error_monitor.sv */
// Our own choices: the APB register port and the register offsets.
`include "rem_consts.svh"

// ----------------------------------------
// Receive error monitor, four links, APB slave
// ----------------------------------------
module rem_rx_error_monitor
   import rem_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Per-link event strobes from receivers, one cycle each
   input wire logic [3:0] i_len_err,
   input wire logic [3:0] i_len_stream,
   input wire logic [3:0] i_fix_err,
   input wire logic [11:0] i_fix_type,
   // Interrupt
   output logic o_irq
);
   logic [12:0] len_tally [`REM_LINKS];
   logic [12:0] fix_tally [`REM_LINKS];
   logic [6:0] flags [`REM_LINKS];

   // ----------------------------------------
   // Per-link monitors
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < `REM_LINKS; g++) begin : g_link
         rem_link_mon u_mon (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_len_err(i_len_err[g]),
            .i_len_stream(i_len_stream[g]),
            .i_fix_err(i_fix_err[g]),
            .i_fix_type(i_fix_type[3*g +: 3]),
            .o_len_tally(len_tally[g]),
            .o_fix_tally(fix_tally[g]),
            .o_flags(flags[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // Whole module state
   // ----------------------------------------
   typedef struct packed {
      rem_bus_st_t bus;
      logic [1:0] sel;
      logic [31:0] irq_stat;
      logic [31:0] irq_mask;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
      logic [3:0] ovf_seen;
   } rem_top_st_t;

   rem_top_st_t st_reg;
   rem_top_st_t st_next;

   logic [31:0] ev_word;
   logic [31:0] rd_word;
   logic rd_hit;
   logic wr_req;

   // Interrupt events: byte per link, len/fix/new overflow
   always_comb begin
      ev_word = 32'h0000_0000;
      for (int k = 0; k < `REM_LINKS; k++) begin
         ev_word[8*k + `REM_IRQ_LEN] = i_len_err[k];
         ev_word[8*k + `REM_IRQ_FIX] = i_fix_err[k];
         ev_word[8*k + `REM_IRQ_OVF] = (fix_tally[k][`REM_OVF_BIT]
            | len_tally[k][`REM_OVF_BIT]) & ~st_reg.ovf_seen[k];
      end
   end

   // Read mux, selected link shown; reads change nothing
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      case (i_paddr)
         `REM_OFF_SEL: rd_word = {30'h0000_0000, st_reg.sel};
         `REM_OFF_LEN_TALLY: rd_word = {19'h00000, len_tally[st_reg.sel]};
         `REM_OFF_FLAGS: rd_word = {25'h0000000, flags[st_reg.sel]};
         `REM_OFF_FIX_TALLY: rd_word = {19'h00000, fix_tally[st_reg.sel]};
         `REM_OFF_IRQ_STAT: rd_word = st_reg.irq_stat;
         `REM_OFF_IRQ_MASK: rd_word = st_reg.irq_mask;
         default: rd_hit = 1'b0;
      endcase
   end

   assign wr_req = i_psel & i_penable & i_pwrite;

   // Next state: bus phase, registers, interrupt
   always_comb begin
      st_next = st_reg;
      st_next.pready = 1'b0;
      st_next.pslverr = 1'b0;
      for (int k = 0; k < `REM_LINKS; k++) begin
         if (ev_word[8*k + `REM_IRQ_OVF]) begin
            st_next.ovf_seen[k] = 1'b1;
         end
      end
      case (st_reg.bus)
         REM_BUS_IDLE: begin
            if (i_psel & i_penable) begin
               st_next.bus = REM_BUS_ACCESS;
               st_next.pready = 1'b1;
               st_next.pslverr = ~rd_hit;
               st_next.prdata = i_pwrite ? 32'h0000_0000 : rd_word;
            end
         end
         REM_BUS_ACCESS: begin
            st_next.bus = REM_BUS_DONE;
            if (wr_req && rd_hit) begin
               // Monitor values are read-only; writes there ignored
               case (i_paddr)
                  `REM_OFF_SEL: st_next.sel = i_pwdata[1:0];
                  `REM_OFF_IRQ_MASK: st_next.irq_mask = i_pwdata;
                  default: st_next.sel = st_reg.sel;
               endcase
            end
         end
         REM_BUS_DONE: st_next.bus = REM_BUS_IDLE;
         default: st_next.bus = REM_BUS_IDLE;
      endcase
      // Write-one-to-clear, new event wins over clear
      if (st_reg.bus == REM_BUS_ACCESS && wr_req && i_paddr == `REM_OFF_IRQ_STAT) begin
         st_next.irq_stat = (st_reg.irq_stat & ~i_pwdata) | ev_word;
      end else begin
         st_next.irq_stat = st_reg.irq_stat | ev_word;
      end
      st_next.irq = |(st_next.irq_stat & st_next.irq_mask);
   end

   // State register
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_reg.bus <= REM_BUS_IDLE;
         st_reg.sel <= 2'h0;
         st_reg.irq_stat <= `REM_RST_WORD;
         st_reg.irq_mask <= `REM_RST_WORD;
         st_reg.prdata <= `REM_RST_WORD;
         st_reg.pready <= 1'b0;
         st_reg.pslverr <= 1'b0;
         st_reg.irq <= 1'b0;
         st_reg.ovf_seen <= 4'h0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_prdata = st_reg.prdata;
   assign o_pready = st_reg.pready;
   assign o_pslverr = st_reg.pslverr;
   assign o_irq = st_reg.irq;
endmodule : rem_rx_error_monitor

/* bench/rem_cam_model.sv */
// ----------------------------------------
// Camera side: one receive event per request
// ----------------------------------------
module rem_cam_model (
   input wire logic i_clk,
   input wire logic i_go,
   input wire logic [1:0] i_link,
   input wire logic [1:0] i_kind,
   input wire logic [2:0] i_type,
   output logic [3:0] o_len_err = 4'h0,
   output logic [3:0] o_len_stream = 4'h0,
   output logic [3:0] o_fix_err = 4'h0,
   output logic [11:0] o_fix_type = 12'h5A5
);
   timeunit 1ns;
   timeprecision 1ns;
   // Kind 0 length error, 1 stream length error, 2 corrected error
   always @(posedge i_clk) begin
      o_len_err <= (i_go && i_kind < 2'h2) ? 4'h1 << i_link : 4'h0;
      o_fix_err <= (i_go && i_kind == 2'h2) ? 4'h1 << i_link : 4'h0;
      // Qualifiers scramble when no event, so stale values never help
      o_len_stream <= i_go ? ((i_kind == 2'h1) ? 4'h1 << i_link : 4'h0) : ~o_len_stream;
      o_fix_type <= i_go ? {4{i_type}} : ~o_fix_type;
   end
endmodule : rem_cam_model

/* bench/rem_rx_chk.sv */
// ----------------------------------------
// Port checks for the error monitor
// ----------------------------------------
module rem_rx_chk (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [3:0] i_len_err,
   input wire logic [3:0] i_fix_err,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic o_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // Bus answer timing and codes
   a_ready_pulse: assert property (o_pready |=> !o_pready)
      else $error("pready too long");
   a_ready_after: assert property ($rose(i_penable) && i_psel |=> o_pready)
      else $error("pready late");
   a_ready_sel: assert property (!i_psel |=> !o_pready)
      else $error("pready unasked");
   a_err_ready: assert property (o_pslverr |-> o_pready)
      else $error("pslverr alone");
   a_data_holds: assert property (!o_pready |-> $stable(o_prdata))
      else $error("prdata moved");
   a_tally_width: assert property (o_pready && !i_pwrite && i_paddr < 12'h010
      |-> o_prdata[31:13] == 19'h0) else $error("upper bits set");
   a_unmapped_err: assert property (o_pready && i_paddr > 12'h014
      |-> o_pslverr && (i_pwrite || o_prdata == 32'h0)) else $error("unmapped accepted");
   a_mapped_ok: assert property (o_pready && i_paddr <= 12'h014
      && i_paddr[1:0] == 2'h0 |-> !o_pslverr) else $error("mapped refused");
   a_reset_quiet: assert property (disable iff (1'b0) i_rst |=> !o_irq && !o_pready)
      else $error("outputs busy after reset");
   // Status and irq register on the same edge as the event or the mask write
   a_irq_cause: assert property ($rose(o_irq)
      |-> $past(|i_fix_err || |i_len_err, 1) || $past(o_pready, 1)) else $error("irq uncaused");
endmodule : rem_rx_chk

bind rem_rx_error_monitor rem_rx_chk rem_rx_chk_inst (.i_clk(i_clk), .i_rst(i_rst),
   .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
   .i_len_err(i_len_err), .i_fix_err(i_fix_err), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq));

/* bench/rem_rx_error_monitor_tb.sv */
module rem_rx_error_monitor_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk = 1'b0, i_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, stat = 32'h0, seed = 32'h7391B247, q, m;
   logic pready, pslverr, irq, r;
   logic [1:0] lnk = 2'h0, knd = 2'h0;
   logic [2:0] typ = 3'h0;
   logic [3:0] len_err, len_stream, fix_err;
   logic [11:0] fix_type;
   logic [6:0] flg [4] = '{default: 7'h00};
   int lcnt [4] = '{default: 0};
   int fcnt [4] = '{default: 0};
   int bad_count = 0, compares = 0;
   rem_rx_error_monitor rem_rx_error_monitor_inst (.i_clk(i_clk), .i_rst(i_rst),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_len_err(len_err), .i_len_stream(len_stream), .i_fix_err(fix_err),
      .i_fix_type(fix_type), .o_irq(irq));
   rem_cam_model rem_cam_model_inst (.i_clk(i_clk), .i_go(go), .i_link(lnk), .i_kind(knd),
      .i_type(typ), .o_len_err(len_err), .o_len_stream(len_stream), .o_fix_err(fix_err),
      .o_fix_type(fix_type));
   // ----------------------------------------
   // Helpers and reference model
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   function automatic logic [31:0] tal(input int n);
      return {19'h0, n > 4095, 12'(n % 4096)};
   endfunction : tal
   task automatic wrap_up();
      if (bad_count == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] g, input logic [31:0] e,
      input logic [31:0] k = 32'hFFFFFFFF);
      compares++;
      if ((g & k) !== (e & k)) begin
         $display("Error %0t got %h expected %h", $time, g, e);
         bad_count++;
      end
   endtask : chk
   // One APB transfer, waits for pready at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      do begin
         @(posedge i_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      r = pslverr;
      if (n >= 50) begin
         bad_count++;
         wrap_up();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge i_clk);
   endtask : apb
   task automatic cmp(input logic [11:0] a, input logic [31:0] e,
      input logic [31:0] k = 32'hFFFFFFFF);
      apb(1'b0, a, 32'h0);
      chk(q, e, k);
   endtask : cmp
   // Event kind t on link k, packet type y
   task automatic ev(input int k, input int t, input int y);
      go <= 1'b1;
      lnk <= 2'(k);
      knd <= 2'(t);
      typ <= 3'(y);
      if (t < 2) begin
         lcnt[k]++;
         stat[8 * k] = 1'b1;
         if (t == 1) flg[k][0] = 1'b1;
         if (lcnt[k] == 4096) stat[8 * k + 2] = 1'b1;
      end else begin
         fcnt[k]++;
         stat[8 * k + 1] = 1'b1;
         if (y < 6) flg[k][y + 1] = 1'b1;
         if (fcnt[k] == 4096) stat[8 * k + 2] = 1'b1;
      end
      @(posedge i_clk);
   endtask : ev
   // ----------------------------------------
   // Clock, watchdog and main sequence
   // ----------------------------------------
   initial begin
      forever #5 i_clk = ~i_clk;
   end
   initial begin
      repeat (30000) @(posedge i_clk);
      bad_count++;
      wrap_up();
   end
   initial begin
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      for (int a = 0; a < 24; a += 4) cmp(12'(a), 32'h0);
      apb(1'b1, 12'h004, 32'hFFFFFFFF);
      cmp(12'h004, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk({31'h0, r}, 32'h1);
      repeat (300) begin
         seed = xs(seed);
         ev(seed % 4, (seed >> 2) % 3, (seed >> 4) % 8);
      end
      repeat (4100) ev(2, 2, 6);
      go <= 1'b0;
      repeat (2) @(posedge i_clk);
      for (int k = 0; k < 4; k++) begin
         m = fcnt[k] > 4095 ? 32'hFFFFF000 : 32'hFFFFFFFF;
         apb(1'b1, 12'h000, 32'(k));
         cmp(12'h000, 32'(k));
         cmp(12'h004, tal(lcnt[k]));
         cmp(12'h008, 32'(flg[k]));
         repeat (2) cmp(12'h00C, tal(fcnt[k]), m);
      end
      chk({31'h0, irq}, 32'h0);
      cmp(12'h010, stat);
      apb(1'b1, 12'h014, 32'h07070707);
      repeat (2) @(posedge i_clk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, 12'h010, stat);
      cmp(12'h010, 32'h0);
      chk({31'h0, irq}, 32'h0);
      cmp(12'h008, 32'(flg[3]));
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      cmp(12'h00C, 32'h0);
      wrap_up();
   end
endmodule : rem_rx_error_monitor_tb
